// ### shared/sensor_measure_command_decoder_regs.vh
// constants of the measurement command decoder: command codes, memory
// addresses, status bit positions, phase indices and reset values
// assumes inclusion by bare name from the core design file
`ifndef SENSOR_MEASURE_COMMAND_DECODER_REGS_VH
`define SENSOR_MEASURE_COMMAND_DECODER_REGS_VH

// ==========================================
// command codes
`define CMD_OVERSAMPLE_4 8'hAD
`define CMD_OVERSAMPLE_8 8'hAE
`define CMD_OVERSAMPLE_16 8'hAF
`define CMD_SELECT_PRIMARY 8'hB0
`define CMD_SELECT_ALTERNATE 8'hB1
`define CMD_HALT_CYCLIC 8'hBF
`define CMD_RAW_HI 5'b1010_0
`define CMD_NOP_HI 4'hF

// ==========================================
// setup memory addresses
`define ADDR_PRIMARY_SETUP 6'h12
`define ADDR_ALTERNATE_SETUP 6'h16

// ==========================================
// status byte bit positions
`define STAT_POWERED 6
`define STAT_BUSY 5
`define STAT_MODE_LO 3
`define STAT_MEM_ERROR 2
`define STAT_SETUP_SEL 1
`define STAT_SATURATION 0

// ==========================================
// phase indices of a full measurement cycle
`define PH_AZ_SENSOR 2'h0
`define PH_SENSOR 2'h1
`define PH_AZ_TEMP 2'h2
`define PH_TEMP 2'h3

// ==========================================
// oversampling counts (minus one) and mean shifts
`define OVS4_LAST 4'h3
`define OVS8_LAST 4'h7
`define OVS16_LAST 4'hF
`define OVS4_SHIFT 3'h2
`define OVS8_SHIFT 3'h3
`define OVS16_SHIFT 3'h4

// ==========================================
// reset values and masks
`define RST_SETUP_SEL 1'b0
`define TEMP_ARG_MASK 16'h0FFF
`define DEF_TEMP_SETUP 16'h0000

`endif

// ### core/sensor_measure_command_decoder.v
// measurement command decoder: oversampled measure, setup selection,
// halt of cyclic operation, spi status poll and raw measurement commands
// assumes a framed command byte plus 16-bit argument, a setup memory read
// port, a phase sequencer and an external correction unit, all on CLK
`timescale 1ns/1ns
`default_nettype none
`include "sensor_measure_command_decoder_regs.vh"

module sensor_measure_command_decoder #(
  parameter [15:0] TEMP_SETUP = `DEF_TEMP_SETUP
) (
  input wire CLK,
  input wire NRST,
  input wire CMD_VALID,
  input wire [7:0] CMD_BYTE,
  input wire [15:0] CMD_ARG,
  input wire SPI_SEL,
  input wire [1:0] MODE_BITS,
  input wire MEM_ERROR,
  output reg MEM_RD,
  output reg [5:0] MEM_ADDR,
  input wire MEM_ACK,
  input wire [15:0] MEM_DATA,
  output reg PHASE_START,
  output reg [1:0] PHASE_SEL,
  output reg [15:0] PHASE_SETUP,
  input wire PHASE_DONE,
  input wire [23:0] PHASE_DATA,
  output reg CORR_START,
  input wire CORR_DONE,
  input wire [23:0] CORR_SENSOR,
  input wire [23:0] CORR_TEMP,
  input wire CORR_SAT,
  input wire CYCLIC_BEGIN,
  output reg CYCLIC_ACTIVE,
  output reg AFE_POWER,
  output reg SLEEP_REQ,
  output reg NOP_READ,
  output wire [7:0] STATUS,
  output reg [23:0] RESULT_SENSOR,
  output reg [23:0] RESULT_TEMP
);

  // ==========================================
  // states
  localparam [4:0] S_IDLE = 5'b00001;
  localparam [4:0] S_FETCH = 5'b00010;
  localparam [4:0] S_PHASE = 5'b00100;
  localparam [4:0] S_CORR = 5'b01000;
  localparam [4:0] S_DONE = 5'b10000;

  // ==========================================
  // reset release
  reg rst_meta_r;
  reg rst_sync_r;
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // ==========================================
  // helpers
  // first phase of a raw command: auto-zero first when bit 1 set
  function [1:0] raw_first;
    input [7:0] c;
    begin
      if (c[2])
        raw_first = c[1] ? `PH_AZ_TEMP : `PH_TEMP;
      else
        raw_first = c[1] ? `PH_AZ_SENSOR : `PH_SENSOR;
    end
  endfunction

  // ==========================================
  // state
  reg [4:0] state_r;
  reg busy_r;
  reg sel_r;
  reg sat_r;
  reg full_r;
  reg az_mode_r;
  reg [1:0] ph_r;
  reg [1:0] last_r;
  reg [3:0] cyc_r;
  reg [2:0] shift_r;
  reg [15:0] setup_r;
  reg [23:0] az_r;
  reg [27:0] acc_s_r;
  reg [27:0] acc_t_r;

  wire take = CMD_VALID && !busy_r && state_r == S_IDLE;
  wire is_raw = CMD_BYTE[7:3] == `CMD_RAW_HI;
  wire is_ovs = CMD_BYTE == `CMD_OVERSAMPLE_4 || CMD_BYTE == `CMD_OVERSAMPLE_8 ||
    CMD_BYTE == `CMD_OVERSAMPLE_16;
  wire [27:0] sum_s = acc_s_r + {4'h0, CORR_SENSOR};
  wire [27:0] sum_t = acc_t_r + {4'h0, CORR_TEMP};
  wire [27:0] mean_s = sum_s >> shift_r;
  wire [27:0] mean_t = sum_t >> shift_r;
  wire [1:0] ph_next = ph_r + 2'h1;
  // temperature phases of a full cycle use the fixed temperature setup
  wire [15:0] setup_for_next = (full_r && ph_next[1]) ? TEMP_SETUP : setup_r;
  wire [15:0] raw_setup = !CMD_BYTE[0] ? TEMP_SETUP :
    CMD_BYTE[2] ? (CMD_ARG & `TEMP_ARG_MASK) : CMD_ARG;

  assign STATUS = {1'b0, 1'b1, busy_r | CYCLIC_ACTIVE, MODE_BITS, MEM_ERROR, sel_r, sat_r};

  always @(posedge CLK or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      state_r <= S_IDLE;
      busy_r <= 1'b0;
      sel_r <= `RST_SETUP_SEL;
      sat_r <= 1'b0;
      full_r <= 1'b0;
      az_mode_r <= 1'b0;
      ph_r <= 2'h0;
      last_r <= 2'h0;
      cyc_r <= 4'h0;
      shift_r <= 3'h0;
      setup_r <= 16'h0000;
      az_r <= 24'h00_0000;
      acc_s_r <= 28'h000_0000;
      acc_t_r <= 28'h000_0000;
      MEM_RD <= 1'b0;
      MEM_ADDR <= 6'h00;
      PHASE_START <= 1'b0;
      PHASE_SEL <= 2'h0;
      PHASE_SETUP <= 16'h0000;
      CORR_START <= 1'b0;
      CYCLIC_ACTIVE <= 1'b0;
      AFE_POWER <= 1'b0;
      SLEEP_REQ <= 1'b0;
      NOP_READ <= 1'b0;
      RESULT_SENSOR <= 24'h00_0000;
      RESULT_TEMP <= 24'h00_0000;
    end else begin
      MEM_RD <= 1'b0;
      PHASE_START <= 1'b0;
      CORR_START <= 1'b0;
      SLEEP_REQ <= 1'b0;
      NOP_READ <= 1'b0;
      case (state_r)
        S_IDLE: begin
          if (take) begin
            if (is_ovs) begin
              busy_r <= 1'b1;
              sat_r <= 1'b0;
              full_r <= 1'b1;
              az_mode_r <= 1'b0;
              ph_r <= `PH_AZ_SENSOR;
              last_r <= `PH_TEMP;
              acc_s_r <= 28'h000_0000;
              acc_t_r <= 28'h000_0000;
              if (CMD_BYTE == `CMD_OVERSAMPLE_4) begin
                cyc_r <= `OVS4_LAST;
                shift_r <= `OVS4_SHIFT;
              end else if (CMD_BYTE == `CMD_OVERSAMPLE_8) begin
                cyc_r <= `OVS8_LAST;
                shift_r <= `OVS8_SHIFT;
              end else begin
                cyc_r <= `OVS16_LAST;
                shift_r <= `OVS16_SHIFT;
              end
              MEM_RD <= 1'b1;
              MEM_ADDR <= sel_r ? `ADDR_ALTERNATE_SETUP : `ADDR_PRIMARY_SETUP;
              AFE_POWER <= 1'b1;
              state_r <= S_FETCH;
            end else if (CMD_BYTE == `CMD_SELECT_PRIMARY) begin
              busy_r <= 1'b1;
              sat_r <= 1'b0;
              sel_r <= 1'b0;
              state_r <= S_DONE;
            end else if (CMD_BYTE == `CMD_SELECT_ALTERNATE) begin
              busy_r <= 1'b1;
              sat_r <= 1'b0;
              sel_r <= 1'b1;
              state_r <= S_DONE;
            end else if (CMD_BYTE == `CMD_HALT_CYCLIC) begin
              sat_r <= 1'b0;
              CYCLIC_ACTIVE <= 1'b0;
              AFE_POWER <= 1'b0;
              SLEEP_REQ <= 1'b1;
            end else if (CMD_BYTE[7:4] == `CMD_NOP_HI && SPI_SEL) begin
              NOP_READ <= 1'b1;
            end else if (is_raw) begin
              busy_r <= 1'b1;
              sat_r <= 1'b0;
              full_r <= 1'b0;
              az_mode_r <= CMD_BYTE[1];
              ph_r <= raw_first(CMD_BYTE);
              last_r <= CMD_BYTE[2] ? `PH_TEMP : `PH_SENSOR;
              AFE_POWER <= 1'b1;
              if (CMD_BYTE[0] || CMD_BYTE[2]) begin
                setup_r <= raw_setup;
                PHASE_SETUP <= raw_setup;
                PHASE_SEL <= raw_first(CMD_BYTE);
                PHASE_START <= 1'b1;
                state_r <= S_PHASE;
              end else begin
                MEM_RD <= 1'b1;
                MEM_ADDR <= sel_r ? `ADDR_ALTERNATE_SETUP : `ADDR_PRIMARY_SETUP;
                state_r <= S_FETCH;
              end
            end
          end
        end
        S_FETCH: begin
          if (MEM_ACK) begin
            setup_r <= MEM_DATA;
            PHASE_SETUP <= MEM_DATA;
            PHASE_SEL <= ph_r;
            PHASE_START <= 1'b1;
            state_r <= S_PHASE;
          end
        end
        S_PHASE: begin
          if (PHASE_DONE) begin
            if (ph_r == `PH_AZ_SENSOR || ph_r == `PH_AZ_TEMP)
              az_r <= PHASE_DATA;
            if (ph_r == last_r) begin
              if (full_r) begin
                CORR_START <= 1'b1;
                state_r <= S_CORR;
              end else begin
                // 24-bit wrap of the offset-corrected raw value
                RESULT_SENSOR <= az_mode_r ? PHASE_DATA - az_r : PHASE_DATA;
                RESULT_TEMP <= 24'h00_0000;
                state_r <= S_DONE;
              end
            end else begin
              ph_r <= ph_next;
              PHASE_SEL <= ph_next;
              PHASE_SETUP <= setup_for_next;
              PHASE_START <= 1'b1;
            end
          end
        end
        S_CORR: begin
          if (CORR_DONE) begin
            sat_r <= sat_r | CORR_SAT;
            if (cyc_r == 4'h0) begin
              RESULT_SENSOR <= mean_s[23:0];
              RESULT_TEMP <= mean_t[23:0];
              state_r <= S_DONE;
            end else begin
              acc_s_r <= sum_s;
              acc_t_r <= sum_t;
              cyc_r <= cyc_r - 4'h1;
              ph_r <= `PH_AZ_SENSOR;
              PHASE_SEL <= `PH_AZ_SENSOR;
              PHASE_SETUP <= setup_r;
              PHASE_START <= 1'b1;
              state_r <= S_PHASE;
            end
          end
        end
        S_DONE: begin
          busy_r <= 1'b0;
          if (!CYCLIC_ACTIVE && !CYCLIC_BEGIN)
            AFE_POWER <= 1'b0;
          state_r <= S_IDLE;
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
      if (CYCLIC_BEGIN) begin
        CYCLIC_ACTIVE <= 1'b1;
        AFE_POWER <= 1'b1;
      end
    end
  end

endmodule // sensor_measure_command_decoder
`default_nettype wire

// ### dv/sensor_measure_command_decoder_checker.sv
// checker: port relations of the measurement command decoder
// assumes bind onto the decoder top, input names equal to its ports
`timescale 1ns/1ns
`default_nettype none
module measure_cmd_checker (
  input wire CLK,
  input wire NRST,
  input wire CMD_VALID,
  input wire [7:0] CMD_BYTE,
  input wire [15:0] CMD_ARG,
  input wire SPI_SEL,
  input wire MEM_RD,
  input wire [5:0] MEM_ADDR,
  input wire PHASE_START,
  input wire [1:0] PHASE_SEL,
  input wire [15:0] PHASE_SETUP,
  input wire PHASE_DONE,
  input wire CORR_DONE,
  input wire CYCLIC_BEGIN,
  input wire CYCLIC_ACTIVE,
  input wire AFE_POWER,
  input wire SLEEP_REQ,
  input wire NOP_READ,
  input wire [7:0] STATUS
);
  default clocking dc @(posedge CLK);
  endclocking
  default disable iff (!NRST);
  wire take = CMD_VALID && !STATUS[5];
  wire sel_cmd = take && CMD_BYTE[7:1] == 7'h58;
  // =====================================
  // assertions
  a_halt_sleep: assert property (
    CMD_VALID && CMD_BYTE == 8'hBF && CYCLIC_ACTIVE && !CYCLIC_BEGIN |=>
    SLEEP_REQ && !CYCLIC_ACTIVE && !AFE_POWER)
    else $error("halt did not reach sleep");
  a_select_bit: assert property (sel_cmd |=> STATUS[1] == $past(CMD_BYTE[0]))
    else $error("setup select bit wrong");
  a_select_busy: assert property (sel_cmd |=> STATUS[5] ##1 !STATUS[5])
    else $error("select busy length wrong");
  a_busy_refuse: assert property (
    CMD_VALID && STATUS[5] && !CYCLIC_ACTIVE |=> $stable(STATUS[1]))
    else $error("command taken while busy");
  a_nop_cause: assert property (
    NOP_READ |-> $past(CMD_VALID && SPI_SEL && CMD_BYTE[7:4] == 4'hF))
    else $error("nop answer without spi nop");
  a_mem_addr: assert property (MEM_RD |-> MEM_ADDR == (STATUS[1] ? 6'h16 : 6'h12))
    else $error("wrong setup address");
  a_phase_order: assert property (
    PHASE_DONE && !PHASE_SEL[0] |=> PHASE_START && PHASE_SEL == {$past(PHASE_SEL[1]), 1'b1})
    else $error("phase order broken");
  a_no_pause: assert property (
    CORR_DONE && !CYCLIC_ACTIVE |=> (PHASE_START && PHASE_SEL == 2'h0) or (1'b1 ##1 !STATUS[5]))
    else $error("pause between cycles");
  a_power_on: assert property (PHASE_START || PHASE_DONE || CORR_DONE |-> AFE_POWER)
    else $error("front end off mid measurement");
  a_arg_setup: assert property (
    take && (CMD_BYTE == 8'hA1 || CMD_BYTE == 8'hA3) |=> PHASE_START && PHASE_SETUP == $past(CMD_ARG))
    else $error("host setup not used");
  a_temp_mask: assert property (
    take && (CMD_BYTE == 8'hA5 || CMD_BYTE == 8'hA7) |=> PHASE_SETUP == ($past(CMD_ARG) & 16'h0FFF))
    else $error("temp setup not masked");
endmodule // measure_cmd_checker
bind sensor_measure_command_decoder measure_cmd_checker chk (.*);
`default_nettype wire

// ### dv/measure_far_side.sv
// far-side model: setup memory, phase sequencer, correction unit
// assumes one-cycle request pulses launched on the rising edge of CLK
`timescale 1ns/1ns
`default_nettype none
module measure_far_side (
  input wire CLK,
  input wire SLOW,
  input wire SAT,
  input wire MEM_RD,
  input wire [5:0] MEM_ADDR,
  output logic MEM_ACK,
  output logic [15:0] MEM_DATA,
  input wire PHASE_START,
  input wire [1:0] PHASE_SEL,
  input wire [15:0] PHASE_SETUP,
  output logic PHASE_DONE,
  output logic [23:0] PHASE_DATA,
  input wire CORR_START,
  output logic CORR_DONE,
  output logic [23:0] CORR_SENSOR,
  output logic [23:0] CORR_TEMP,
  output logic CORR_SAT,
  output int ncorr
);
  logic tog;
  initial {MEM_ACK, MEM_DATA, PHASE_DONE, PHASE_DATA, tog, ncorr} = '0;
  initial {CORR_DONE, CORR_SENSOR, CORR_TEMP, CORR_SAT} = '0;
  // data lines show the inverse once the strobe drops
  always @(posedge CLK) if (MEM_RD) begin
    repeat (SLOW ? 5 : 0) @(posedge CLK);
    MEM_ACK <= 1'b1;
    MEM_DATA <= MEM_ADDR == 6'h16 ? 16'h5A3C : 16'h0F96;
    @(posedge CLK);
    MEM_ACK <= 1'b0;
    MEM_DATA <= ~MEM_DATA;
  end
  // phase data echoes setup and phase index
  always @(posedge CLK) if (PHASE_START) begin
    repeat (SLOW ? 5 : 0) @(posedge CLK);
    PHASE_DONE <= 1'b1;
    PHASE_DATA <= {4'h0, PHASE_SETUP, 2'b00, PHASE_SEL};
    @(posedge CLK);
    PHASE_DONE <= 1'b0;
    PHASE_DATA <= ~PHASE_DATA;
  end
  // alternating results so a mean differs from any single cycle
  always @(posedge CLK) if (CORR_START) begin
    repeat (SLOW ? 5 : 0) @(posedge CLK);
    CORR_DONE <= 1'b1;
    CORR_SAT <= SAT;
    CORR_SENSOR <= tog ? 24'h80_0002 : 24'h80_0000;
    CORR_TEMP <= tog ? 24'h40_0004 : 24'h40_0000;
    tog <= ~tog;
    ncorr <= ncorr + 1;
    @(posedge CLK);
    CORR_DONE <= 1'b0;
    CORR_SAT <= ~CORR_SAT;
    CORR_SENSOR <= ~CORR_SENSOR;
    CORR_TEMP <= ~CORR_TEMP;
  end
endmodule // measure_far_side
`default_nettype wire

// ### dv/sensor_measure_command_decoder_bench.sv
// testbench: decoder with far-side model and bound checker
// assumes inputs driven at the falling edge, 25 MHz clock
`timescale 1ns/1ns
`default_nettype none
module sensor_measure_command_decoder_bench;
  logic CLK, NRST, CMD_VALID, SPI_SEL, MEM_ERROR, CYCLIC_BEGIN, SLOW, SAT, alt;
  logic [7:0] CMD_BYTE;
  logic [15:0] CMD_ARG;
  logic [1:0] MODE_BITS;
  wire MEM_RD, MEM_ACK, PHASE_START, PHASE_DONE, CORR_START, CORR_DONE, CORR_SAT;
  wire CYCLIC_ACTIVE, AFE_POWER, SLEEP_REQ, NOP_READ;
  wire [5:0] MEM_ADDR;
  wire [1:0] PHASE_SEL;
  wire [15:0] MEM_DATA, PHASE_SETUP;
  wire [23:0] PHASE_DATA, CORR_SENSOR, CORR_TEMP, RESULT_SENSOR, RESULT_TEMP;
  wire [7:0] STATUS;
  int ncorr;
  int n_errors = 0;
  int tests_run = 0;
  int i;
  sensor_measure_command_decoder DUT (.*);
  measure_far_side far (.*);
  always #20 CLK = ~CLK;
  // =====================================
  // shared tasks
  task chk(input [23:0] got, input [23:0] exp, input string msg);
    begin
      tests_run++;
      if (got !== exp) begin
        n_errors++;
        $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
      end
    end
  endtask
  task send(input [7:0] c, input [15:0] a);
    begin
      @(negedge CLK);
      {CMD_VALID, CMD_BYTE, CMD_ARG} = {1'b1, c, a};
      @(negedge CLK);
      CMD_VALID = 1'b0;
    end
  endtask
  task wait_idle;
    int k;
    begin
      for (k = 0; k < 3000 && STATUS[5] !== 1'b0; k++) @(negedge CLK);
      if (STATUS[5] !== 1'b0) begin
        chk(24'h00_0001, 24'h00_0000, "busy hang");
        stop_test;
      end
    end
  endtask
  function [23:0] exp_raw(input [7:0] c, input [15:0] a);
    reg [15:0] s;
    begin
      s = c[0] ? (c[2] ? a & 16'h0FFF : a) : (c[2] ? 16'h0000 : (alt ? 16'h5A3C : 16'h0F96));
      exp_raw = c[1] ? 24'h00_0001 : {4'h0, s, 2'b00, c[2], 1'b1};
    end
  endfunction
  // =====================================
  // scenarios
  task t_raw(input [7:0] c, input [15:0] a);
    begin
      send(c, a);
      wait_idle;
      chk(RESULT_SENSOR, exp_raw(c, a), "raw result");
      chk(RESULT_TEMP, 24'h00_0000, "raw second word");
    end
  endtask
  task t_select(input b);
    begin
      send({7'h58, b}, 16'h0000);
      alt = b;
      chk(STATUS[5], 1'b1, "select busy");
      chk(STATUS[1], b, "select bit");
      repeat (2) @(negedge CLK);
      chk(STATUS[5], 1'b0, "select done");
    end
  endtask
  task t_ovs(input [7:0] c, input [23:0] n, input s);
    int n0;
    begin
      n0 = ncorr;
      SAT = s;
      send(c, 16'h0000);
      send({7'h58, ~alt}, 16'h0000);
      chk(STATUS[1], alt, "select while busy");
      wait_idle;
      chk(ncorr - n0, n, "cycle count");
      chk(RESULT_SENSOR, 24'h80_0001, "sensor mean");
      chk(RESULT_TEMP, 24'h40_0002, "temp mean");
      chk(STATUS[0], s, "saturation");
    end
  endtask
  task stop_test;
    begin
      $display("errors %0d checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  initial begin
    {CLK, NRST, CMD_VALID, CMD_BYTE, CMD_ARG, SPI_SEL} = '0;
    {MODE_BITS, MEM_ERROR, CYCLIC_BEGIN, SLOW, SAT, alt} = 7'b01_1_0_0_0_0;
    repeat (3) @(negedge CLK);
    NRST = 1'b1;
    repeat (3) @(negedge CLK);
    chk(STATUS, 8'h4C, "reset status");
    t_raw(8'hA0, 16'h0000);
    t_select(1'b1);
    for (i = 0; i < 8; i++) t_raw(8'hA0 + i[7:0], i[0] ? 16'hF123 : 16'h0000);
    t_ovs(8'hAD, 24'd4, 1'b0);
    SLOW = 1'b1;
    t_ovs(8'hAE, 24'd8, 1'b1);
    t_ovs(8'hAF, 24'd16, 1'b0);
    SLOW = 1'b0;
    t_select(1'b0);
    SPI_SEL = 1'b1;
    send(8'hF5, 16'h0000);
    chk(NOP_READ, 1'b1, "spi nop");
    SPI_SEL = 1'b0;
    send(8'hF5, 16'h0000);
    chk(NOP_READ, 1'b0, "nop outside spi");
    @(negedge CLK) CYCLIC_BEGIN = 1'b1;
    @(negedge CLK) CYCLIC_BEGIN = 1'b0;
    chk(STATUS[5], 1'b1, "cyclic busy");
    send(8'hBF, 16'h0000);
    chk(SLEEP_REQ, 1'b1, "sleep pulse");
    chk({CYCLIC_ACTIVE, AFE_POWER}, 2'b00, "halted");
    stop_test;
  end
endmodule // sensor_measure_command_decoder_bench
`default_nettype wire
